// File: common/fsr_pkg.sv
// Constants and types shared by the flash status register logic.
package fsr_pkg;

	localparam logic [7:0] OPC_READ_STATUS   = 8'h05;
	localparam logic [7:0] OPC_ACTIVE_STATUS = 8'h25;
	localparam logic [7:0] OPC_WRITE_STATUS  = 8'h01;
	localparam logic [7:0] OPC_WRITE_STATUS2 = 8'h31;
	localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OPC_SOFT_RESET    = 8'hF0;

	localparam int STATUS_BITS = 16;
	localparam int LOCK_BIT    = 7;
	localparam int GLOB_HI     = 5;
	localparam int GLOB_LO     = 2;
	localparam int SOFT_RESET_ENABLE_BIT    = 4;

	localparam logic [2:0] BIT_LAST    = 3'h7;
	localparam logic [1:0] BYTES_OPC   = 2'h1;
	localparam logic [1:0] BYTES_DATA  = 2'h2;
	localparam logic [3:0] OUT_IDX_TOP = 4'hF;

	localparam logic [1:0] SWP_NONE = 2'h0;
	localparam logic [1:0] SWP_SOME = 2'h1;
	localparam logic [1:0] SWP_ALL  = 2'h3;

	localparam logic LOCK_RST = 1'b0;
	localparam logic WEL_RST  = 1'b0;
	localparam logic ERR_RST  = 1'b0;
	localparam logic SOFT_RESET_ENABLE_RST = 1'b0;

	typedef struct packed {
		logic busy;
		logic op_done;
		logic op_fail;
		logic op_end;
		logic seq_mode;
		logic seq_end;
		logic hold_abort;
	} fsr_core_s;

	typedef struct packed {
		logic       write_en;
		logic       prot_cmd_ok;
		logic       lock;
		logic       reset_en;
		logic       glob_req;
		logic [3:0] glob_code;
		logic       soft_reset;
	} fsr_ctl_s;

endpackage

// File: dv/fsr_chk.sv
// Port checker for the flash status register block, bound into its top.
`timescale 1ns/100ps
module fsr_chk (
	input wire logic               sys_clk,
	input wire logic               nrst,
	input wire logic               wp_n,
	input wire logic               spi_cs_n,
	input wire fsr_pkg::fsr_core_s core_evt,
	input wire logic               spi_so_oe,
	input wire fsr_pkg::fsr_ctl_s  ctl
);
	import fsr_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// ----------
	// Properties
	// ----------
	property p_glob; ctl.glob_req |-> !$past(ctl.lock); endproperty
	a_glob: assert property (p_glob) else $error("global request while locked.");
	property p_rst; $rose(nrst) |-> ctl == '0; endproperty
	a_rst: assert property (p_rst) else $error("control not clear after reset.");
	// The pin is synchronised, so outside a soft reset the lock may only fall two or three cycles after the pin is seen high.
	property p_wp; $fell(ctl.lock) |-> $past(wp_n, 2) || $past(wp_n, 3) || ctl.soft_reset;
	endproperty
	a_wp: assert property (p_wp) else $error("lock cleared with pin asserted.");
	property p_lock; $rose(ctl.lock) |-> $past(ctl.write_en); endproperty
	a_lock: assert property (p_lock) else $error("lock set without latch.");
	property p_clr; core_evt.op_end || core_evt.seq_end || core_evt.hold_abort
		|-> ##[0:3] !ctl.write_en; endproperty
	a_clr: assert property (p_clr) else $error("latch not cleared.");
	property p_gate; ctl.soft_reset |-> ctl.reset_en; endproperty
	a_gate: assert property (p_gate) else $error("reset accepted while disabled.");
	property p_keep; ctl.soft_reset |=> ctl.reset_en [*3]; endproperty
	a_keep: assert property (p_keep) else $error("reset enable lost.");
	property p_soft_reset_enable; $changed(ctl.reset_en) |-> $past(ctl.write_en); endproperty
	a_soft_reset_enable: assert property (p_soft_reset_enable) else $error("reset enable changed without latch.");
	property p_oe; spi_cs_n |-> !spi_so_oe; endproperty
	a_oe: assert property (p_oe) else $error("output driven while deselected.");
endmodule
bind fsr_status_regs fsr_chk fsr_chk_i (.sys_clk(sys_clk), .nrst(nrst), .wp_n(wp_n),
	.spi_cs_n(spi_cs_n), .core_evt(core_evt), .spi_so_oe(spi_so_oe), .ctl(ctl));

// File: dv/fsr_spi_host.sv
// Behavioural SPI host that clocks frames into the status block.
`timescale 1ns/100ps
module fsr_spi_host (
	output logic      spi_sck,
	output logic      spi_cs_n,
	output logic      spi_si,
	input  wire logic spi_so
);
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	// The clock stands at its idle level outside frames; idle high selects mode 3.
	task automatic frame(input logic [23:0] d, input int n, input logic m3, input logic hold,
		output logic [23:0] rx);
		rx = 24'h0;
		spi_sck = m3;
		#150 spi_cs_n = 1'b0;
		#150;
		for (int i = 0; i < n; i++) begin
			if (m3) #3 spi_sck = 1'b0;
			spi_si = d[23-i];
			#3 spi_sck = 1'b1;
			rx = {rx[22:0], spi_so};
			if (!m3) #3 spi_sck = 1'b0;
		end
		#3 spi_si = ~spi_si;
		if (!hold) spi_cs_n = 1'b1;
	endtask
	task automatic drop();
		#3 spi_cs_n = 1'b1;
	endtask
endmodule

// File: dv/test_flash_status_register_logic.sv
// Self-checking bench for the flash status register block.
`timescale 1ns/100ps
module test_flash_status_register_logic;
	import fsr_pkg::*;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        wp_n = 1'b1;
	logic [6:0]  ev = 7'h0;
	logic [7:0]  sp = 8'h0;
	logic [23:0] rx;
	logic [3:0]  gcode = 4'h0;
	logic        l, e, w, r;
	logic [6:0]  clr [3] = '{7'h08, 7'h02, 7'h01};
	wire logic   spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, so_line;
	fsr_ctl_s    ctl;
	int          n_fail = 0;
	int          comparisons = 0;
	int          n_gr = 0;
	int          n_sr = 0;
	always #25 sys_clk = ~sys_clk;
	fsr_status_regs fsr_status_regs_i (.sys_clk(sys_clk), .nrst(nrst), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_si(spi_si), .wp_n(wp_n), .core_evt(fsr_core_s'(ev)),
		.sector_prot(sp), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .ctl(ctl));
	// Nothing drives the line while deselected; the host then sees the inverse,
	// so a sample taken while the output floats shows up as a mismatch.
	assign so_line = spi_so_oe ? spi_so : ~spi_so;
	fsr_spi_host fsr_spi_host_i (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
		.spi_so(so_line));
	always @(posedge sys_clk) begin
		if (ctl.soft_reset === 1'b1) n_sr++;
		if (ctl.glob_req === 1'b1) begin
			n_gr++;
			gcode = ctl.glob_code;
		end
	end
	// -------------
	// Helpers
	// -------------
	function automatic logic [15:0] exp_st();
		logic [1:0] s;
		s = (sp == 8'h00) ? SWP_NONE : (&sp) ? SWP_ALL : SWP_SOME;
		return {l, ev[2], e, wp_n, s, w, ev[6], 3'h0, r, 3'h0, ev[6]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [23:0] d, input int n, input logic m3 = 1'b0,
		input logic hold = 1'b0);
		fsr_spi_host_i.frame(d, n, m3, hold, rx);
		repeat (8) @(posedge sys_clk);
	endtask
	task automatic wren();
		cmd({OPC_WRITE_ENABLE, 16'h0}, 8);
		w = 1'b1;
	endtask
	task automatic pulse(input logic [6:0] m);
		@(posedge sys_clk) ev <= ev | m;
		@(posedge sys_clk) ev <= ev & ~m;
		repeat (3) @(posedge sys_clk);
	endtask
	// Each read also checks the protection, lock, latch and reset enable outputs, so stale state shows up at once.
	task automatic rd_chk();
		cmd({OPC_READ_STATUS, 16'h0}, 24, 1'($urandom % 2));
		chk(rx[15:0], exp_st());
		chk({12'h0, ctl.prot_cmd_ok, ctl.lock, ctl.write_en, ctl.reset_en},
			{12'h0, w && !l, l, w, r});
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#2_000_000;
		n_fail++;
		print_verdict();
	end
	// -------------
	// Tests
	// -------------
	initial begin
		rx = 24'($urandom(22));
		{l, e, w, r} = 4'h0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd_chk();
		cmd({OPC_WRITE_STATUS, 16'h8000}, 16);
		rd_chk();
		wren();
		cmd({OPC_WRITE_STATUS, 16'hFF00}, 16);
		{l, w} = 2'b10;
		rd_chk();
		chk({12'h0, gcode}, 16'h000F);
		wren();
		cmd({OPC_WRITE_STATUS, 16'hBC00}, 16);
		w = 1'b0;
		rd_chk();
		chk(16'(n_gr), 16'h1);
		@(posedge sys_clk) wp_n <= 1'b0;
		wren();
		cmd({OPC_WRITE_STATUS, 16'h0}, 16);
		w = 1'b0;
		rd_chk();
		@(posedge sys_clk) wp_n <= 1'b1;
		wren();
		cmd({OPC_WRITE_STATUS, 16'h0}, 16);
		{l, w} = 2'b00;
		rd_chk();
		tend("lock");
		for (int i = 0; i < 3; i++) begin
			wren();
			pulse(clr[i]);
			w = 1'b0;
			rd_chk();
		end
		wren();
		cmd({OPC_WRITE_STATUS, 16'h0}, 5);
		rd_chk();
		cmd({OPC_WRITE_DISABLE, 16'h0}, 8);
		w = 1'b0;
		rd_chk();
		tend("latch");
		pulse(7'h30);
		e = 1'b1;
		rd_chk();
		pulse(7'h08);
		rd_chk();
		pulse(7'h20);
		e = 1'b0;
		rd_chk();
		pulse(7'h30);
		e = 1'b1;
		cmd({OPC_SOFT_RESET, 16'h0}, 8);
		rd_chk();
		chk(16'(n_sr), 16'h0);
		wren();
		cmd({OPC_WRITE_STATUS2, 16'h1000}, 16);
		{w, r} = 2'b01;
		rd_chk();
		wren();
		cmd({OPC_WRITE_STATUS2, 16'h0}, 12);
		w = 1'b0;
		rd_chk();
		wren();
		cmd({OPC_SOFT_RESET, 16'h0}, 8);
		{e, w} = 2'b00;
		rd_chk();
		chk(16'(n_sr), 16'h1);
		tend("reset");
		repeat (8) begin
			@(posedge sys_clk);
			wp_n <= 1'($urandom);
			sp <= ($urandom % 3 == 0) ? 8'hFF : 8'($urandom & 32'h81);
			ev <= {1'($urandom), 3'h0, 1'($urandom), 2'h0};
			repeat (4) @(posedge sys_clk);
			rd_chk();
		end
		tend("random");
		for (int m = 0; m < 2; m++) begin
			@(posedge sys_clk) ev <= 7'h40;
			cmd({OPC_ACTIVE_STATUS, 16'h0}, 8 + m, 1'(m), 1'b1);
			chk({14'h0, spi_so_oe, spi_so}, 16'h3);
			@(posedge sys_clk) ev <= 7'h00;
			repeat (4) @(posedge sys_clk);
			chk({14'h0, spi_so_oe, spi_so}, 16'h2);
			fsr_spi_host_i.drop();
			repeat (2) @(posedge sys_clk);
			chk({15'h0, spi_so_oe}, 16'h0);
		end
		tend("active");
		print_verdict();
	end
endmodule

// File: rtl/fsr_status_regs.sv
// Status bytes, protection lock, write enable latch and active status output.
`timescale 1ns/100ps
module fsr_status_regs #(
	parameter int SECTORS = 8
) (
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	input  wire logic                  spi_sck,
	input  wire logic                  spi_cs_n,
	input  wire logic                  spi_si,
	input  wire logic                  wp_n,
	input  wire fsr_pkg::fsr_core_s    core_evt,
	input  wire logic [SECTORS-1:0]    sector_prot,
	output logic                       spi_so,
	output logic                       spi_so_oe,
	output fsr_pkg::fsr_ctl_s          ctl
);
	import fsr_pkg::*;

	// ----------------------------------------------------------------
	// Link side: receive shifter, cleared while chip select is high
	// ----------------------------------------------------------------
	logic [2:0] bit_idx_reg;
	logic [1:0] byte_cnt_reg;
	logic [6:0] rx_sh_reg;
	logic       rd_req_reg;
	logic       asi_req_reg;
	logic       dummy_reg;
	logic [7:0] rx_byte;

	assign rx_byte = {rx_sh_reg, spi_si};

	always_ff @(posedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			bit_idx_reg  <= '0;
			byte_cnt_reg <= '0;
			rx_sh_reg    <= '0;
			rd_req_reg   <= 1'b0;
			asi_req_reg  <= 1'b0;
			dummy_reg    <= 1'b0;
		end else begin
			bit_idx_reg <= bit_idx_reg + 3'h1;
			rx_sh_reg   <= rx_byte[6:0];
			if (byte_cnt_reg != '0) begin
				dummy_reg <= 1'b1;
			end
			if (bit_idx_reg == BIT_LAST && byte_cnt_reg != BYTES_DATA) begin
				byte_cnt_reg <= byte_cnt_reg + 2'h1;
			end
			if (bit_idx_reg == BIT_LAST && byte_cnt_reg == '0) begin
				rd_req_reg  <= (rx_byte == OPC_READ_STATUS);
				asi_req_reg <= (rx_byte == OPC_ACTIVE_STATUS);
			end
		end
	end

	// ----------------------------------------------------------------
	// Link side: frame record, kept after chip select rises
	// ----------------------------------------------------------------
	// The link clock stops between frames, so this record stays still and
	// the system side reads it after the synchronised chip select release.
	// A host that moves its clock idle level while deselected makes an edge
	// here, so the record only follows edges inside a frame.
	logic [7:0] opcode_reg;
	logic [7:0] data_reg;
	logic [1:0] bytes_done_reg;
	logic       odd_reg;
	logic       frame_tog_reg;

	always_ff @(posedge spi_sck or negedge nrst) begin
		if (!nrst) begin
			opcode_reg     <= '0;
			data_reg       <= '0;
			bytes_done_reg <= '0;
			odd_reg        <= 1'b0;
			frame_tog_reg  <= 1'b0;
		end else if (!spi_cs_n) begin
			odd_reg <= (bit_idx_reg != BIT_LAST);
			if (bit_idx_reg == '0 && byte_cnt_reg == '0) begin
				frame_tog_reg  <= ~frame_tog_reg;
				bytes_done_reg <= '0;
			end
			if (bit_idx_reg == BIT_LAST) begin
				if (byte_cnt_reg == '0) begin
					opcode_reg <= rx_byte;
				end
				if (byte_cnt_reg == BYTES_OPC) begin
					data_reg <= rx_byte;
				end
				if (byte_cnt_reg != BYTES_DATA) begin
					bytes_done_reg <= byte_cnt_reg + 2'h1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Link side: status word synchroniser and output shifter
	// ----------------------------------------------------------------
	logic [STATUS_BITS-1:0] stat_reg;
	logic [STATUS_BITS-1:0] stat_l1_reg;
	logic [STATUS_BITS-1:0] stat_l2_reg;
	logic [STATUS_BITS-1:0] stat_l3_reg;
	logic [STATUS_BITS-1:0] stat_cp_reg;
	logic [3:0]             out_idx_reg;
	logic                   so_link_reg;
	logic                   so_en_link_reg;

	// Only a word seen alike on two link edges is shifted out, so flags that
	// change together never reach the host torn apart.
	always_ff @(posedge spi_sck or negedge nrst) begin
		if (!nrst) begin
			stat_l1_reg <= '0;
			stat_l2_reg <= '0;
			stat_l3_reg <= '0;
			stat_cp_reg <= '0;
		end else begin
			stat_l1_reg <= stat_reg;
			stat_l2_reg <= stat_l1_reg;
			stat_l3_reg <= stat_l2_reg;
			if (stat_l3_reg == stat_l2_reg) begin
				stat_cp_reg <= stat_l3_reg;
			end
		end
	end

	always_ff @(negedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			out_idx_reg    <= '0;
			so_link_reg    <= 1'b0;
			so_en_link_reg <= 1'b0;
		end else if (rd_req_reg) begin
			so_link_reg    <= stat_cp_reg[OUT_IDX_TOP - out_idx_reg];
			out_idx_reg    <= out_idx_reg + 4'h1;
			so_en_link_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// System side: pin and link synchronisers
	// ----------------------------------------------------------------
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
	logic sck_s1_reg, sck_s2_reg;
	logic wp_s1_reg, wp_s2_reg;
	logic asi_s1_reg, asi_s2_reg;
	logic dum_s1_reg, dum_s2_reg;
	logic tog_s1_reg, tog_s2_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cs_s1_reg  <= 1'b1;
			cs_s2_reg  <= 1'b1;
			cs_s3_reg  <= 1'b1;
			sck_s1_reg <= 1'b0;
			sck_s2_reg <= 1'b0;
			wp_s1_reg  <= 1'b1;
			wp_s2_reg  <= 1'b1;
			asi_s1_reg <= 1'b0;
			asi_s2_reg <= 1'b0;
			dum_s1_reg <= 1'b0;
			dum_s2_reg <= 1'b0;
			tog_s1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
		end else begin
			cs_s1_reg  <= spi_cs_n;
			cs_s2_reg  <= cs_s1_reg;
			cs_s3_reg  <= cs_s2_reg;
			sck_s1_reg <= spi_sck;
			sck_s2_reg <= sck_s1_reg;
			wp_s1_reg  <= wp_n;
			wp_s2_reg  <= wp_s1_reg;
			asi_s1_reg <= asi_req_reg;
			asi_s2_reg <= asi_s1_reg;
			dum_s1_reg <= dummy_reg;
			dum_s2_reg <= dum_s1_reg;
			tog_s1_reg <= frame_tog_reg;
			tog_s2_reg <= tog_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// System side: mode detect and active status output
	// ----------------------------------------------------------------
	logic mode3_reg;
	logic asi_on_reg;
	logic so_asi_reg;
	logic asi_next;

	assign asi_next = asi_s2_reg && !cs_s2_reg && (!mode3_reg || dum_s2_reg);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mode3_reg <= 1'b0;
		end else if (cs_s3_reg && !cs_s2_reg) begin
			mode3_reg <= sck_s2_reg;
		end
	end

	// Busy only falls during an operation, so following it live gives the
	// one falling edge on the output that the host waits on.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			asi_on_reg <= 1'b0;
			so_asi_reg <= 1'b0;
		end else begin
			asi_on_reg <= asi_next;
			so_asi_reg <= core_evt.busy;
		end
	end

	// Select release gates the enable directly so the pin floats at once.
	assign spi_so    = asi_on_reg ? so_asi_reg : so_link_reg;
	assign spi_so_oe = !spi_cs_n && (asi_on_reg || so_en_link_reg);

	// ----------------------------------------------------------------
	// System side: frame decode at chip select release
	// ----------------------------------------------------------------
	logic tog_seen_reg;
	logic frame_end;
	logic full_opc;
	logic full_data;
	logic is_wrsr;
	logic is_wrsr2;
	logic wrsr_ok;
	logic wrsr2_ok;
	logic sreset_ok;
	logic lock_blocked;

	assign frame_end = cs_s2_reg && !cs_s3_reg && (tog_s2_reg != tog_seen_reg);
	assign full_opc  = frame_end && (bytes_done_reg >= BYTES_OPC);
	assign full_data = full_opc && (bytes_done_reg == BYTES_DATA);
	assign is_wrsr   = opcode_reg == OPC_WRITE_STATUS;
	assign is_wrsr2  = opcode_reg == OPC_WRITE_STATUS2;

	assign lock_blocked = ctl.lock && !data_reg[LOCK_BIT] && !wp_s2_reg;
	assign wrsr_ok      = full_data && is_wrsr && ctl.write_en && !lock_blocked;
	assign wrsr2_ok     = full_data && !odd_reg && is_wrsr2 && ctl.write_en;
	assign sreset_ok    = full_opc && !odd_reg && (opcode_reg == OPC_SOFT_RESET)
		&& ctl.reset_en;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tog_seen_reg <= 1'b0;
		end else if (frame_end) begin
			tog_seen_reg <= tog_s2_reg;
		end
	end

	// ----------------------------------------------------------------
	// System side: control registers
	// ----------------------------------------------------------------
	logic wel_set;
	logic wel_clr;
	logic err_reg;
	logic [1:0] swp_reg;

	assign wel_set = full_opc && (opcode_reg == OPC_WRITE_ENABLE);
	assign wel_clr = core_evt.op_end || core_evt.seq_end || core_evt.hold_abort
		|| (full_opc && (opcode_reg == OPC_WRITE_DISABLE || is_wrsr || is_wrsr2))
		|| sreset_ok;

	// A new set wins over a clear that lands in the same cycle.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctl.write_en <= WEL_RST;
		end else if (wel_set) begin
			ctl.write_en <= 1'b1;
		end else if (wel_clr) begin
			ctl.write_en <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctl.lock <= LOCK_RST;
		end else if (sreset_ok) begin
			ctl.lock <= LOCK_RST;
		end else if (wrsr_ok) begin
			ctl.lock <= data_reg[LOCK_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctl.glob_req  <= 1'b0;
			ctl.glob_code <= '0;
		end else begin
			ctl.glob_req <= wrsr_ok && !ctl.lock;
			if (wrsr_ok) begin
				ctl.glob_code <= data_reg[GLOB_HI:GLOB_LO];
			end
		end
	end

	// Reset enable is cleared by power-up or a second status write with bit 4 low, never by the soft reset.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctl.reset_en <= SOFT_RESET_ENABLE_RST;
		end else if (wrsr2_ok) begin
			ctl.reset_en <= data_reg[SOFT_RESET_ENABLE_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctl.soft_reset  <= 1'b0;
			ctl.prot_cmd_ok <= 1'b0;
		end else begin
			ctl.soft_reset  <= sreset_ok;
			ctl.prot_cmd_ok <= ctl.write_en && !ctl.lock;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			err_reg <= ERR_RST;
		end else if (core_evt.op_done) begin
			err_reg <= core_evt.op_fail;
		end else if (sreset_ok) begin
			err_reg <= ERR_RST;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			swp_reg <= SWP_NONE;
		end else if (&sector_prot) begin
			swp_reg <= SWP_ALL;
		end else if (|sector_prot) begin
			swp_reg <= SWP_SOME;
		end else begin
			swp_reg <= SWP_NONE;
		end
	end

	// ----------------------------------------------------------------
	// System side: status word
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stat_reg <= '0;
		end else begin
			stat_reg <= {ctl.lock, core_evt.seq_mode, err_reg, wp_s2_reg,
				swp_reg, ctl.write_en, core_evt.busy,
				3'h0, ctl.reset_en, 3'h0, core_evt.busy};
		end
	end

endmodule
